// ==== status_regs.svh ====
// Constants of the status-reporting block: bit positions, masks and reset values.
// Assumes it is included by its bare name wherever these values are needed.
`ifndef STATUS_REGS_SVH
`define STATUS_REGS_SVH

// ----------------------------------------------------------------------------
// Status summary byte
// ----------------------------------------------------------------------------
`define STB_QSB_BIT 3
`define STB_MAV_BIT 4
`define STB_ESB_BIT 5
`define STB_RQS_BIT 6
`define STB_USED_MASK 8'h78
`define SRE_WRITE_MASK 8'hbf

// ----------------------------------------------------------------------------
// Standard event flags
// ----------------------------------------------------------------------------
`define ESR_OPC_BIT 0
`define ESR_QYE_BIT 2
`define ESR_DDE_BIT 3
`define ESR_EXE_BIT 4
`define ESR_CME_BIT 5
`define ESR_PON_BIT 7
`define ESR_USED_MASK 8'hbd

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define MASK_RESET 8'h00
`define ESR_RESET 8'h00
`define RSP_RESET 8'h00

`endif

// ==== status_pkg.sv ====
// Types shared by the status-reporting block and its user.
// Assumes the command parser hands over one decoded common command at a time.
package status_pkg;

    typedef enum logic [3:0] {
        op_clear_status,
        op_sre_write,
        op_sre_query,
        op_ese_write,
        op_ese_query,
        op_esr_query,
        op_stb_query,
        op_opc,
        op_ques_query
    } cmd_op_e;

    typedef struct packed {
        cmd_op_e op;
        logic [7:0] data;
    } cmd_s;

    typedef enum logic [1:0] {
        err_query,
        err_device,
        err_exec,
        err_command
    } err_class_e;

    typedef struct packed {
        logic push;
        logic from_queue_read;
        err_class_e cls;
    } errq_s;

    typedef struct packed {
        logic empty_read;
        logic line_before_read;
        logic buffers_full;
        logic self_test_fail;
        logic cal_fail;
        logic overload;
        logic exec_err;
        logic cmd_err;
    } evt_s;

endpackage : status_pkg

// ==== sticky_bits.sv ====
// Set-dominant sticky flag register.
// Assumes set and clear are synchronous one-cycle strobes on clk.
`timescale 1ns/1ns

module sticky_bits #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Control
    input wire logic [W-1:0] set,
    input wire logic clear,
    // State
    output logic [W-1:0] q
);

    // A flag raised in the same cycle as a clear survives it.
    logic [W-1:0] q_next;

    assign q_next = (clear ? '0 : q) | set;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= q_next;
        end
    end

endmodule : sticky_bits

// ==== gpib_status_reporting.sv ====
// Status byte, standard event register and service request of a bus-attached meter.
// Assumes decoded common commands, serial poll strobes and event pulses, all on clk.
`timescale 1ns/1ns
`include "status_regs.svh"

module gpib_status_reporting (
    // Clock and reset; reset stands for power-on
    input wire logic clk,
    input wire logic rstn,
    // Non-volatile power-on settings
    input wire logic psc_stored,
    input wire logic [7:0] saved_sre_mask,
    input wire logic [7:0] saved_ese_mask,
    // Decoded common commands
    input wire logic cmd_valid,
    input wire status_pkg::cmd_s cmd,
    input wire logic cmds_pending,
    output logic cmd_ready,
    // Query answers
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    // Serial poll
    input wire logic spoll_req,
    output logic spoll_valid,
    output logic [7:0] spoll_data,
    // Device conditions
    input wire logic out_buf_nonempty,
    input wire status_pkg::evt_s evt,
    input wire status_pkg::errq_s errq,
    input wire logic [15:0] ques_event,
    input wire logic [15:0] ques_enable,
    // Status outputs
    output logic srq,
    output logic [7:0] status_byte
);

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        por_load,
        por_run
    } por_state_e;

    por_state_e por_reg;
    por_state_e por_next;
    logic [7:0] sre_reg;
    logic [7:0] sre_next;
    logic [7:0] ese_reg;
    logic [7:0] ese_next;
    logic rqs_reg;
    logic rqs_next;
    logic req_prev_reg;
    logic rsp_valid_reg;
    logic [7:0] rsp_data_reg;
    logic [7:0] rsp_data_next;
    logic spoll_valid_reg;
    logic [7:0] spoll_data_reg;
    logic [7:0] esr;

    // ------------------------------------------------------------------------
    // Command acceptance
    // ------------------------------------------------------------------------
    // Ordered commands wait for everything issued earlier to finish.
    wire ordered_op = (cmd.op == status_pkg::op_stb_query) || (cmd.op == status_pkg::op_opc);
    assign cmd_ready = !(ordered_op && cmds_pending);
    wire acc = cmd_valid && cmd_ready;
    wire acc_cls = acc && (cmd.op == status_pkg::op_clear_status);
    wire acc_esr_q = acc && (cmd.op == status_pkg::op_esr_query);
    wire acc_ques_q = acc && (cmd.op == status_pkg::op_ques_query);
    wire acc_stb_q = acc && (cmd.op == status_pkg::op_stb_query);
    wire acc_opc = acc && (cmd.op == status_pkg::op_opc);
    wire acc_sre_w = acc && (cmd.op == status_pkg::op_sre_write);
    wire acc_ese_w = acc && (cmd.op == status_pkg::op_ese_write);
    wire acc_query = acc && (cmd.op inside {status_pkg::op_sre_query, status_pkg::op_ese_query,
                                            status_pkg::op_esr_query, status_pkg::op_stb_query});

    // ------------------------------------------------------------------------
    // Standard event flags
    // ------------------------------------------------------------------------
    wire errq_new = errq.push && !errq.from_queue_read;
    wire set_qye = evt.empty_read || evt.line_before_read || evt.buffers_full
                   || (errq_new && errq.cls == status_pkg::err_query);
    wire set_dde = evt.self_test_fail || evt.cal_fail || evt.overload
                   || (errq_new && errq.cls == status_pkg::err_device);
    wire set_exe = evt.exec_err || (errq_new && errq.cls == status_pkg::err_exec);
    wire set_cme = evt.cmd_err || (errq_new && errq.cls == status_pkg::err_command);
    wire set_pon = (por_reg == por_load);
    wire [7:0] esr_set = {set_pon, 1'b0, set_cme, set_exe, set_dde, set_qye, 1'b0, acc_opc};
    wire esr_clear = acc_cls || acc_esr_q;

    // Only a read, clear-status or power-on reset empties the flags; reset commands never reach here.
    sticky_bits #(
        .W(8)
    ) esr_flags (
        .clk(clk),
        .rstn(rstn),
        .set(esr_set & `ESR_USED_MASK),
        .clear(esr_clear),
        .q(esr)
    );

    // ------------------------------------------------------------------------
    // Status summary byte
    // ------------------------------------------------------------------------
    wire qsb = |(ques_event & ques_enable);
    wire esb = |(esr & ese_reg & `ESR_USED_MASK);
    wire mav = out_buf_nonempty;
    wire [7:0] summary = {1'b0, 1'b0, esb, mav, qsb, 3'b000};
    assign status_byte = summary | ({7'h00, rqs_reg} << `STB_RQS_BIT);

    // ------------------------------------------------------------------------
    // Service request
    // ------------------------------------------------------------------------
    // Request follows the rise of the OR of all enabled summaries; bit 6 of the mask is not used.
    wire req_now = |(summary & sre_reg & `STB_USED_MASK);
    wire rqs_set = req_now && !req_prev_reg;
    wire rqs_by_esr = acc_esr_q && esb && sre_reg[`STB_ESB_BIT];
    wire rqs_by_ques = acc_ques_q && qsb && sre_reg[`STB_QSB_BIT];
    wire rqs_clear = spoll_req || rqs_by_esr || rqs_by_ques || acc_cls;
    assign rqs_next = rqs_set || (rqs_reg && !rqs_clear);
    assign srq = rqs_reg;

    // ------------------------------------------------------------------------
    // Enable masks and power-on handling
    // ------------------------------------------------------------------------
    wire por_clear = psc_stored;
    assign por_next = por_run;
    wire [7:0] sre_power_on = por_clear ? `MASK_RESET : (saved_sre_mask & `SRE_WRITE_MASK);
    assign sre_next = (por_reg == por_load) ? sre_power_on
                    : acc_sre_w ? (cmd.data & `SRE_WRITE_MASK) : sre_reg;
    assign ese_next = (por_reg == por_load) ? (por_clear ? `MASK_RESET : saved_ese_mask)
                    : acc_ese_w ? cmd.data : ese_reg;

    // ------------------------------------------------------------------------
    // Query answers
    // ------------------------------------------------------------------------
    // Answers carry plain binary; the formatter turns them into decimal text.
    always_comb begin
        case (cmd.op)
            status_pkg::op_sre_query: rsp_data_next = sre_reg;
            status_pkg::op_ese_query: rsp_data_next = ese_reg;
            status_pkg::op_esr_query: rsp_data_next = esr;
            status_pkg::op_stb_query: rsp_data_next = status_byte;
            default: rsp_data_next = `RSP_RESET;
        endcase
    end

    assign rsp_valid = rsp_valid_reg;
    assign rsp_data = rsp_data_reg;
    assign spoll_valid = spoll_valid_reg;
    assign spoll_data = spoll_data_reg;

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            por_reg <= por_load;
            sre_reg <= `MASK_RESET;
            ese_reg <= `MASK_RESET;
        end else begin
            case (por_reg)
                por_load: por_reg <= por_next;
                por_run: por_reg <= por_run;
                default: por_reg <= por_run;
            endcase
            sre_reg <= sre_next;
            ese_reg <= ese_next;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rqs_reg <= 1'b0;
            req_prev_reg <= 1'b0;
        end else begin
            rqs_reg <= rqs_next;
            req_prev_reg <= req_now;
        end
    end

    // A serial poll samples the byte and clears the request bit; measurements never wait on it.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rsp_valid_reg <= 1'b0;
            rsp_data_reg <= `RSP_RESET;
            spoll_valid_reg <= 1'b0;
            spoll_data_reg <= `RSP_RESET;
        end else begin
            rsp_valid_reg <= acc_query;
            rsp_data_reg <= acc_query ? rsp_data_next : rsp_data_reg;
            spoll_valid_reg <= spoll_req;
            spoll_data_reg <= spoll_req ? status_byte : spoll_data_reg;
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    mav_follow_a: assert property (@(posedge clk) disable iff (!rstn)
        status_byte[`STB_MAV_BIT] == out_buf_nonempty)
        else $error("message available does not follow output buffer");

    qsb_summary_a: assert property (@(posedge clk) disable iff (!rstn)
        status_byte[`STB_QSB_BIT] == |(ques_event & ques_enable))
        else $error("questionable summary wrong");

    esb_summary_a: assert property (@(posedge clk) disable iff (!rstn)
        status_byte[`STB_ESB_BIT] == |(esr & ese_reg))
        else $error("standard event summary wrong");

    srq_raise_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(req_now) |=> srq)
        else $error("service request not raised");

    spoll_clear_a: assert property (@(posedge clk) disable iff (!rstn)
        spoll_req && !rqs_set |=> !srq && spoll_valid && spoll_data == $past(status_byte))
        else $error("serial poll answer or clear wrong");

    stb_query_a: assert property (@(posedge clk) disable iff (!rstn)
        acc_stb_q && srq && !spoll_req && !acc_cls |=> srq && rsp_valid
        && rsp_data == $past(status_byte))
        else $error("status byte query changed bit 6 or answered wrongly");

    ordered_wait_a: assert property (@(posedge clk) disable iff (!rstn)
        cmd_valid && ordered_op && cmds_pending |-> !cmd_ready)
        else $error("ordered command taken while earlier commands pending");

    esr_clear_a: assert property (@(posedge clk) disable iff (!rstn)
        esr_clear |=> esr == ($past(esr_set) & `ESR_USED_MASK))
        else $error("event register not cleared");

    unused_zero_a: assert property (@(posedge clk) disable iff (!rstn)
        (status_byte & ~`STB_USED_MASK) == 8'h00 && (esr & ~`ESR_USED_MASK) == 8'h00)
        else $error("unused bit set");

    power_on_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(rstn) |=> esr[`ESR_PON_BIT]
        && (!$past(psc_stored) || (sre_reg == 8'h00 && ese_reg == 8'h00)))
        else $error("power-on handling wrong");

    opc_set_a: assert property (@(posedge clk) disable iff (!rstn)
        acc_opc |=> esr[`ESR_OPC_BIT])
        else $error("operation complete not flagged");

    // The checks below, up to ese_zero_a, pin down the clearing side of flags and masks, which the
    // summary checks above would not notice if a clear were lost or spurious.
    rqs_by_read_a: assert property (@(posedge clk) disable iff (!rstn)
        acc_esr_q && status_byte[`STB_ESB_BIT] && sre_reg[`STB_ESB_BIT] && !rqs_set |=> !srq)
        else $error("request service not cleared by event register read");

    cls_clear_a: assert property (@(posedge clk) disable iff (!rstn)
        acc_cls && !rqs_set |=> !srq && (esr & ~$past(esr_set)) == 8'h00)
        else $error("clear status left a bit set");

    esr_latch_a: assert property (@(posedge clk) disable iff (!rstn)
        !esr_clear |=> (esr & $past(esr)) == $past(esr))
        else $error("event flag dropped without a read or clear");

    sre_zero_a: assert property (@(posedge clk) disable iff (!rstn)
        acc_sre_w && cmd.data == 8'h00 && por_reg == por_run |=> sre_reg == 8'h00)
        else $error("writing zero did not clear the service request mask");

    ese_zero_a: assert property (@(posedge clk) disable iff (!rstn)
        acc_ese_w && cmd.data == 8'h00 && por_reg == por_run |=> ese_reg == 8'h00)
        else $error("writing zero did not clear the event mask");

    err_class_a: assert property (@(posedge clk) disable iff (!rstn)
        errq_new && errq.cls == status_pkg::err_exec |=> esr[`ESR_EXE_BIT])
        else $error("queued execution error not flagged");

    spoll_srq_c: cover property (@(posedge clk) disable iff (!rstn) srq ##1 spoll_req);
    esr_read_c: cover property (@(posedge clk) disable iff (!rstn) acc_esr_q && esb);
    stb_wait_c: cover property (@(posedge clk) disable iff (!rstn)
        cmd_valid && !cmd_ready ##1 acc_stb_q);
    pon_mask_c: cover property (@(posedge clk) disable iff (!rstn)
        $rose(rstn) ##2 sre_reg != 8'h00);

endmodule : gpib_status_reporting

// ==== bus_controller.sv ====
// Behavioural bus controller that issues decoded common commands and serial polls.
// Assumes the status block takes a command at an edge where cmd_valid and cmd_ready are high.
`timescale 1ns/1ns

module bus_controller (
    // Clock and handshake
    input wire logic clk,
    input wire logic cmd_ready,
    // Requests
    output logic cmd_valid,
    output status_pkg::cmd_s cmd,
    output logic spoll_req
);
    initial begin
        cmd_valid = 1'b0;
        cmd = '0;
        spoll_req = 1'b0;
    end

    // ------------------------------------------------------------------
    // Requests
    // ------------------------------------------------------------------
    // The command is held until it is taken or 200 more refused cycles pass; a refused query simply waits.
    task automatic send(input status_pkg::cmd_op_e op, input logic [7:0] data);
        int n;
        n = 0;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd <= '{op: op, data: data};
        @(posedge clk);
        while (cmd_ready !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        cmd_valid <= 1'b0;
    endtask : send

    task automatic poll();
        @(posedge clk);
        spoll_req <= 1'b1;
        @(posedge clk);
        spoll_req <= 1'b0;
    endtask : poll
endmodule : bus_controller

// ==== gpib_status_reporting_bench.sv ====
// Self-checking bench for the status-reporting block with a cycle model beside it.
// Assumes bus_controller drives the command and poll side; the bench drives device events.
`timescale 1ns/1ns

module gpib_status_reporting_bench;
    logic clk, rstn, psc_stored, cmds_pending, out_buf_nonempty, cmd_ready;
    logic rsp_valid, spoll_valid, srq, cmd_valid, spoll_req;
    logic [7:0] saved_sre_mask, saved_ese_mask, rsp_data, spoll_data, status_byte;
    logic [15:0] ques_event, ques_enable;
    status_pkg::cmd_s cmd;
    status_pkg::evt_s evt;
    status_pkg::errq_s errq;
    int fail_count = 0;
    int num_checks = 0;
    integer seed = 32'h2cd8edce;
    bit rnd_on = 0;
    int m_esr, m_sre, m_ese, por_cnt;
    bit m_rqs;
    int prev_sum;
    int rsp_q[$];
    int spl_q[$];

    gpib_status_reporting dut (.clk(clk), .rstn(rstn), .psc_stored(psc_stored),
        .saved_sre_mask(saved_sre_mask), .saved_ese_mask(saved_ese_mask),
        .cmd_valid(cmd_valid), .cmd(cmd), .cmds_pending(cmds_pending), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .spoll_req(spoll_req),
        .spoll_valid(spoll_valid), .spoll_data(spoll_data),
        .out_buf_nonempty(out_buf_nonempty), .evt(evt), .errq(errq),
        .ques_event(ques_event), .ques_enable(ques_enable), .srq(srq),
        .status_byte(status_byte));

    bus_controller ctl (.clk(clk), .cmd_ready(cmd_ready), .cmd_valid(cmd_valid), .cmd(cmd),
        .spoll_req(spoll_req));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // Reference model
    // ------------------------------------------------------------------
    function automatic logic [7:0] exp_stb();
        logic esb;
        esb = (m_esr & m_ese & 8'hbd) != 0;
        return {1'b0, m_rqs, esb, out_buf_nonempty, |(ques_event & ques_enable), 3'b000};
    endfunction : exp_stb

    // Sees the inputs as they were before this edge, the same as the design does.
    always @(posedge clk) begin
        int setb, sum;
        bit tk, clr;
        logic [7:0] st;
        if (!rstn) begin
            m_esr = 0; m_sre = 0; m_ese = 0; m_rqs = 0; prev_sum = 0; por_cnt = 0;
            rsp_q.delete();
            spl_q.delete();
        end else begin
            tk = cmd_valid && !(cmds_pending && (cmd.op == status_pkg::op_stb_query
                || cmd.op == status_pkg::op_opc));
            setb = 0;
            if (evt.empty_read || evt.line_before_read || evt.buffers_full) setb |= 4;
            if (evt.self_test_fail || evt.cal_fail || evt.overload) setb |= 8;
            if (evt.exec_err) setb |= 16;
            if (evt.cmd_err) setb |= 32;
            if (errq.push && !errq.from_queue_read) setb |= 4 << errq.cls;
            st = exp_stb();
            if (spoll_req) spl_q.push_back(st);
            sum = (st >> 3) & (m_sre >> 3) & 7;
            clr = spoll_req || tk && (cmd.op == status_pkg::op_clear_status
                || cmd.op == status_pkg::op_esr_query && m_sre[5] && st[5]
                || cmd.op == status_pkg::op_ques_query && m_sre[3] && st[3]);
            if (tk) begin
                case (cmd.op)
                    status_pkg::op_clear_status: m_esr = 0;
                    status_pkg::op_sre_write: m_sre = cmd.data & 8'hbf;
                    status_pkg::op_ese_write: m_ese = cmd.data;
                    status_pkg::op_sre_query: rsp_q.push_back(m_sre);
                    status_pkg::op_ese_query: rsp_q.push_back(m_ese);
                    status_pkg::op_esr_query: begin
                        rsp_q.push_back(m_esr);
                        m_esr = 0;
                    end
                    status_pkg::op_stb_query: rsp_q.push_back(exp_stb());
                    status_pkg::op_opc: setb |= 1;
                    default: ;
                endcase
            end
            if (por_cnt == 0) begin
                m_sre = psc_stored ? 0 : saved_sre_mask & 8'hbf;
                m_ese = psc_stored ? 0 : saved_ese_mask;
                setb |= 128;
            end
            if (por_cnt < 2) por_cnt++;
            m_esr |= setb;
            if (sum != 0 && prev_sum == 0) m_rqs = 1;
            else if (clr) m_rqs = 0;
            prev_sum = sum;
        end
    end

    // ------------------------------------------------------------------
    // Comparison
    // ------------------------------------------------------------------
    task automatic compare_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : compare_byte

    task automatic compare_bit(input string name, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %b seen %b", name, exp, got);
        end
    endtask : compare_bit

    always @(posedge clk) begin
        #1;
        compare_byte("status_byte", exp_stb(), status_byte);
        compare_bit("srq", m_rqs, srq);
        compare_bit("cmd_ready", !(cmds_pending && (cmd.op == status_pkg::op_stb_query
            || cmd.op == status_pkg::op_opc)), cmd_ready);
        compare_bit("rsp_valid", rsp_q.size() != 0, rsp_valid);
        if (rsp_q.size() != 0) compare_byte("rsp_data", 8'(rsp_q.pop_front()), rsp_data);
        compare_bit("spoll_valid", spl_q.size() != 0, spoll_valid);
        if (spl_q.size() != 0) compare_byte("spoll_data", 8'(spl_q.pop_front()), spoll_data);
    end

    // ------------------------------------------------------------------
    // Device-side stimulus
    // ------------------------------------------------------------------
    // Events are kept sparse so that flags are often read back one at a time.
    always @(posedge clk) begin
        if (rnd_on) begin
            evt <= (($random(seed) & 3) == 0) ? status_pkg::evt_s'(8'h01 << ($random(seed) & 7))
                : '0;
            errq <= (($random(seed) & 15) == 0) ? status_pkg::errq_s'(4'h8 | 4'($random(seed)))
                : '0;
            cmds_pending <= ($random(seed) & 3) == 0;
            if (($random(seed) & 15) == 0) out_buf_nonempty <= ~out_buf_nonempty;
            if (($random(seed) & 15) == 0) ques_event <= 16'($random(seed));
            if (($random(seed) & 31) == 0) ques_enable <= 16'($random(seed));
        end else begin
            evt <= '0;
            errq <= '0;
            cmds_pending <= 1'b0;
        end
    end

    task automatic stop_test();
        if (fail_count == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : stop_test

    task automatic power_on(input logic psc);
        rnd_on = 0;
        @(posedge clk);
        rstn <= 1'b0;
        psc_stored <= psc;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
    endtask : power_on

    task automatic traffic(input int n);
        logic [3:0] op;
        rnd_on = 1;
        repeat (n) begin
            op = 4'(($random(seed) & 32'h7fffffff) % 9);
            ctl.send(status_pkg::cmd_op_e'(op), 8'($random(seed)) & 8'hbd);
            if (srq === 1'b1 || ($random(seed) & 7) == 0) ctl.poll();
        end
    endtask : traffic

    initial begin
        rstn = 1'b0;
        psc_stored = 1'b1;
        saved_sre_mask = 8'h38;
        saved_ese_mask = 8'hbd;
        cmds_pending = 1'b0;
        out_buf_nonempty = 1'b0;
        evt = '0;
        errq = '0;
        ques_event = 16'h0000;
        ques_enable = 16'h0000;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        ctl.send(status_pkg::op_sre_query, 8'h00);
        ctl.send(status_pkg::op_ese_query, 8'h00);
        ctl.send(status_pkg::op_esr_query, 8'h00);
        ctl.send(status_pkg::op_esr_query, 8'h00);
        ctl.send(status_pkg::op_ese_write, 8'hbd);
        ctl.send(status_pkg::op_sre_write, 8'h78);
        traffic(300);
        ctl.send(status_pkg::op_sre_write, 8'h00);
        ctl.send(status_pkg::op_sre_query, 8'h00);
        ctl.send(status_pkg::op_ese_write, 8'h00);
        ctl.send(status_pkg::op_ese_query, 8'h00);
        power_on(1'b0);
        ctl.send(status_pkg::op_sre_query, 8'h00);
        ctl.send(status_pkg::op_ese_query, 8'h00);
        traffic(200);
        repeat (2) @(posedge clk);
        stop_test();
    end

    // The run needs about 1500 cycles; this bound of 10000 cycles is far beyond that.
    initial begin
        #200000;
        fail_count++;
        stop_test();
    end
endmodule : gpib_status_reporting_bench
